// file: design/pbc_top.sv
// Pushbutton on/off controller with debounce, latch, interrupt pulse and AHB-Lite registers
`timescale 1ns/1ps
`default_nettype none
module pbc_top #(
    parameter logic [31:0] DB_SHORT_CYC = pbc_pkg::DB_SHORT_CYC,
    parameter logic [31:0] DB_LONG_CYC  = pbc_pkg::DB_LONG_CYC,
    parameter logic [31:0] SO_SHORT_CYC = pbc_pkg::SO_SHORT_CYC,
    parameter logic [31:0] SO_LONG_CYC  = pbc_pkg::SO_LONG_CYC,
    parameter logic [31:0] PULSE0_CYC   = pbc_pkg::PULSE0_CYC,
    parameter logic [31:0] PULSE1_CYC   = pbc_pkg::PULSE1_CYC,
    parameter logic [31:0] PULSE2_CYC   = pbc_pkg::PULSE2_CYC,
    parameter logic [31:0] PULSE3_CYC   = pbc_pkg::PULSE3_CYC
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [7:0]  haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic [31:0]      hrdata,
    output logic             hreadyout,
    output logic             hresp,
    input  wire logic        pushbutton_input_n,
    input  wire logic        force_off_n,
    output logic             latch_out,
    output logic             int_n
);
    pbc_pkg::pbc_ctrl_s   ctrl_r;
    pbc_pkg::pbc_state_e  st_r, st_nxt;
    pbc_pkg::pbc_status_s status;
    logic [31:0]          cnt_r, cnt_nxt;
    logic [31:0]          db_cyc, so_cyc, pulse_cyc, pulse_len;
    logic                 accept, so_evt, pulse_load, lock_load, lock_busy;
    logic                 latch_r, latch_nxt, clr_n, pb_low;
    logic                 wr_pend_r;
    logic [7:0]           wr_addr_r;
    logic                 addr_ph;
    logic [31:0]          rd_word;

    // Pulse length for an option code; used for pulse, long pulse and lockout
    function automatic logic [31:0] pulse_of(input logic [1:0] sel);
        unique case (sel)
            2'h0: pulse_of = PULSE0_CYC;
            2'h1: pulse_of = PULSE1_CYC;
            2'h2: pulse_of = PULSE2_CYC;
            2'h3: pulse_of = PULSE3_CYC;
        endcase
    endfunction

    // Option decode; counts are exact so timing error is only clock error
    assign db_cyc    = ctrl_r.db_long ? DB_LONG_CYC : DB_SHORT_CYC;
    assign so_cyc    = ctrl_r.so_long ? SO_LONG_CYC : SO_SHORT_CYC;
    assign pulse_cyc = pulse_of(ctrl_r.pulse_sel);
    assign pb_low    = !pushbutton_input_n;

    // Press events; the closure counter runs from the first low cycle
    assign accept    = (st_r == pbc_pkg::PBC_DEBOUNCE) && pb_low && (cnt_r == db_cyc - 32'h0000_0001);
    assign so_evt    = (st_r == pbc_pkg::PBC_HELD) && pb_low && (cnt_r == so_cyc - 32'h0000_0001);
    assign pulse_load = accept || so_evt;
    assign pulse_len = so_evt ? 32'(pulse_cyc * pbc_pkg::LONG_PULSE_MULT_W) : pulse_cyc;
    assign lock_load = accept && !latch_r;

    // Press state machine
    always_comb begin
        st_nxt  = st_r;
        cnt_nxt = cnt_r + 32'h0000_0001;
        unique case (st_r)
            pbc_pkg::PBC_IDLE: begin
                cnt_nxt = 32'h0000_0000;
                if (pb_low) begin
                    st_nxt  = pbc_pkg::PBC_DEBOUNCE;
                    cnt_nxt = 32'h0000_0001;
                end
            end
            pbc_pkg::PBC_DEBOUNCE: begin
                if (!pb_low) begin
                    st_nxt  = pbc_pkg::PBC_IDLE;
                    cnt_nxt = 32'h0000_0000;
                end else if (accept) begin
                    st_nxt = pbc_pkg::PBC_HELD;
                end
            end
            pbc_pkg::PBC_HELD: begin
                if (!pb_low) begin
                    st_nxt  = pbc_pkg::PBC_IDLE;
                    cnt_nxt = 32'h0000_0000;
                end else if (so_evt) begin
                    st_nxt = pbc_pkg::PBC_LONG;
                end
            end
            pbc_pkg::PBC_LONG: begin
                cnt_nxt = cnt_r;                                         // Counter parks once shutoff is passed
                if (!pb_low) begin
                    st_nxt  = pbc_pkg::PBC_IDLE;
                    cnt_nxt = 32'h0000_0000;
                end
            end
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r  <= pbc_pkg::PBC_IDLE;
            cnt_r <= 32'h0000_0000;
        end else begin
            st_r  <= st_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // Latch next value; a long press clears it only on the clearing variant
    assign latch_nxt = accept ? 1'b1 : ((so_evt && !ctrl_r.keep_on) ? 1'b0 : latch_r);
    // Clear is masked while the lockout window runs, filtering a bouncing clear line
    assign clr_n = force_off_n || lock_busy;

    // Latch with asynchronous clear, no clock edge needed to turn it off
    always_ff @(posedge hclk or negedge hresetn or negedge clr_n) begin
        if (!hresetn) begin
            latch_r <= 1'b0;
        end else if (!clr_n) begin
            latch_r <= 1'b0;
        end else begin
            latch_r <= latch_nxt;
        end
    end
    assign latch_out = latch_r;

    // Interrupt pulse, active low, retriggered for the long press
    pbc_tmr #(.ACT(1'b0)) u_pulse (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (pulse_load),
        .len     (pulse_len),
        .out_r   (int_n)
    );

    // Clear lockout timer after the latch rises
    pbc_tmr #(.ACT(1'b1)) u_lock (
        .hclk    (hclk),
        .hresetn (hresetn),
        .load    (lock_load),
        .len     (32'(pulse_cyc * pbc_pkg::LOCKOUT_MULT_W)),
        .out_r   (lock_busy)
    );

    // AHB-Lite slave: zero wait states, read data fetched in the address phase
    assign addr_ph = hsel && hready && (|(htrans & pbc_pkg::HTRANS_NONSEQ_BIT));
    assign status  = '{lockout: lock_busy, pulse_on: !int_n, latch_on: latch_r, state: st_r};
    assign rd_word = (haddr == pbc_pkg::CTRL_OFS)   ? 32'(ctrl_r) :
                     (haddr == pbc_pkg::STATUS_OFS) ? 32'(status) : pbc_pkg::ZERO_WORD;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            hrdata    <= pbc_pkg::ZERO_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else begin
            wr_pend_r <= addr_ph && hwrite;
            wr_addr_r <= haddr;
            hrdata    <= (addr_ph && !hwrite) ? rd_word : pbc_pkg::ZERO_WORD;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    // Control write in the data phase; other addresses are ignored
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r <= pbc_pkg::CTRL_RESET;
        end else if (wr_pend_r && (wr_addr_r == pbc_pkg::CTRL_OFS)) begin
            ctrl_r <= pbc_pkg::pbc_ctrl_s'(hwdata[$bits(pbc_pkg::pbc_ctrl_s)-1:0]);
        end
    end

    // Checks
    logic [31:0] low_run_r;

    // Run of low samples, kept apart from the press counter so the check is independent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            low_run_r <= 32'h0000_0000;
        end else begin
            low_run_r <= pb_low ? low_run_r + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    sequence s_accept;
        accept && force_off_n;
    endsequence
    sequence s_long_clear;
        so_evt && !ctrl_r.keep_on;
    endsequence

    a_accept_sets_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        s_accept |=> latch_r)
        else $error("latch not set after accepted press");
    a_accept_pulse_low: assert property (@(posedge hclk) disable iff (!hresetn)
        accept |=> !int_n [*2])
        else $error("interrupt pulse missing after press");
    a_long_pulse_low: assert property (@(posedge hclk) disable iff (!hresetn)
        so_evt |=> !int_n [*8])
        else $error("long press pulse missing");
    a_long_clears_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        s_long_clear |=> !latch_r)
        else $error("long press did not clear latch");
    a_long_keeps_latch: assert property (@(posedge hclk) disable iff (!hresetn)
        so_evt && ctrl_r.keep_on && latch_r && force_off_n |=> latch_r)
        else $error("keep variant lost latch");
    a_clear_forces_off: assert property (@(posedge hclk) disable iff (!hresetn)
        !force_off_n && !lock_busy |-> !latch_r)
        else $error("clear did not force latch off");
    a_lockout_on_rise: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(latch_r) |-> lock_busy)
        else $error("no lockout after latch rise");
    a_debounce_restart: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r == pbc_pkg::PBC_DEBOUNCE && !pb_low |=> st_r == pbc_pkg::PBC_IDLE && cnt_r == 32'h0000_0000)
        else $error("debounce did not restart");
    a_release_needed: assert property (@(posedge hclk) disable iff (!hresetn)
        st_r == pbc_pkg::PBC_LONG && pb_low |=> st_r == pbc_pkg::PBC_LONG)
        else $error("new press seen without release");
    a_accept_timing: assert property (@(posedge hclk) disable iff (!hresetn)
        accept |-> low_run_r == db_cyc - 32'h0000_0001)
        else $error("press accepted too early");
endmodule
`default_nettype wire

// file: shared/pbc_pkg.sv
// Shared constants, register map and types for the pushbutton on/off controller
package pbc_pkg;
    // Clock rate
    localparam longint CLK_HZ = 250_000_000;
    localparam longint MS_PER_S = 1000;

    // Debounce options, in their printed units
    localparam longint DB_SHORT_MS = 50;
    localparam longint DB_LONG_S   = 2;
    // Shutoff options
    localparam longint SO_SHORT_S  = 8;
    localparam longint SO_LONG_S   = 16;
    // Interrupt pulse options
    localparam longint PULSE0_MS   = 8;
    localparam longint PULSE1_MS   = 32;
    localparam longint PULSE2_MS   = 64;
    localparam longint PULSE3_MS   = 128;
    // Lockout and long-pulse multipliers of the pulse duration
    localparam longint LOCKOUT_MULT    = 2;
    localparam longint LONG_PULSE_MULT = 4;

    // Cycle counts derived from the times above
    localparam logic [31:0] DB_SHORT_CYC = 32'(DB_SHORT_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] DB_LONG_CYC  = 32'(DB_LONG_S * CLK_HZ);
    localparam logic [31:0] SO_SHORT_CYC = 32'(SO_SHORT_S * CLK_HZ);
    localparam logic [31:0] SO_LONG_CYC  = 32'(SO_LONG_S * CLK_HZ);
    localparam logic [31:0] PULSE0_CYC   = 32'(PULSE0_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] PULSE1_CYC   = 32'(PULSE1_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] PULSE2_CYC   = 32'(PULSE2_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] PULSE3_CYC   = 32'(PULSE3_MS * CLK_HZ / MS_PER_S);
    localparam logic [31:0] LOCKOUT_MULT_W    = 32'(LOCKOUT_MULT);
    localparam logic [31:0] LONG_PULSE_MULT_W = 32'(LONG_PULSE_MULT);

    // Register map (byte addresses)
    localparam logic [7:0]  CTRL_OFS   = 8'h00;
    localparam logic [7:0]  STATUS_OFS = 8'h04;
    localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
    localparam logic [1:0]  HTRANS_NONSEQ_BIT = 2'h2;

    // Control register fields, low bits of CTRL
    typedef struct packed {
        logic       keep_on;    // 1: long press leaves the output on
        logic       so_long;    // 1: 16 s shutoff
        logic [1:0] pulse_sel;  // 8/32/64/128 ms
        logic       db_long;    // 1: 2 s debounce
    } pbc_ctrl_s;
    localparam pbc_ctrl_s CTRL_RESET = '0;

    // Press tracking states
    typedef enum logic [1:0] {
        PBC_IDLE,
        PBC_DEBOUNCE,
        PBC_HELD,
        PBC_LONG
    } pbc_state_e;

    // Status register fields
    typedef struct packed {
        logic       lockout;
        logic       pulse_on;
        logic       latch_on;
        pbc_state_e state;
    } pbc_status_s;
endpackage

// file: design/pbc_tmr.sv
// One-shot down-counting timer with a registered output level
`timescale 1ns/1ps
`default_nettype none
module pbc_tmr #(
    parameter bit ACT = 1'b1
) (
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        load,
    input  wire logic [31:0] len,
    output logic             out_r
);
    logic [31:0] cnt_r;
    logic        more;
    logic [31:0] cnt_nxt;

    // Output stays active for exactly len cycles after a load
    assign more    = (cnt_r > 32'h0000_0001);
    assign cnt_nxt = load ? len : ((cnt_r != 32'h0000_0000) ? cnt_r - 32'h0000_0001 : cnt_r);

    // Reload wins over the running count, so a retrigger restarts the window
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 32'h0000_0000;
            out_r <= ~ACT;
        end else begin
            cnt_r <= cnt_nxt;
            out_r <= (load ? (len != 32'h0000_0000) : more) ? ACT : ~ACT;
        end
    end
endmodule
`default_nettype wire

// file: tb/pbc_sw_model.sv
// Mechanical pushbutton model with contact chatter and pull-up
`timescale 1ns/1ps
`default_nettype none
module pbc_sw_model (
    input  wire logic hclk,
    input  wire logic closed,
    input  wire logic bounce,
    output logic      pushbutton_input_n
);
    logic       prev;
    logic [2:0] chat;
    initial begin
        prev = 1'b0;
        chat = 3'h0;
        pushbutton_input_n = 1'b1;
    end
    // Contact chatters a few cycles after each change; an open contact reads high
    always @(posedge hclk) begin
        if (closed !== prev) begin
            chat <= bounce ? 3'h4 : 3'h0;
        end else if (chat != 3'h0) begin
            chat <= chat - 3'h1;
        end
        prev <= closed;
        pushbutton_input_n <= (chat != 3'h0) ? ~pushbutton_input_n : ~closed;
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking bench for the pushbutton on/off controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    // Shortened counts so a long press fits in a few hundred cycles
    localparam logic [31:0] DB0 = 32'h0000_0014, DB1 = 32'h0000_0028;
    localparam logic [31:0] SO0 = 32'h0000_00C8, SO1 = 32'h0000_0190;
    localparam logic [31:0] P0 = 32'h0000_0005, P1 = 32'h0000_0008, P2 = 32'h0000_000C, P3 = 32'h0000_0010;
    localparam int          LIM = 5000;
    logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
    logic        closed, bounce, force_off_n, pushbutton_input_n, latch_out, int_n;
    logic [7:0]  haddr;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    logic [31:0] hwdata, hrdata, rd, k32;
    logic [4:0]  ctrl;
    int          error_cnt, n_checks, seed, n, n1, w, k;

    assign hready = hreadyout;
    pbc_top #(.DB_SHORT_CYC(DB0), .DB_LONG_CYC(DB1), .SO_SHORT_CYC(SO0), .SO_LONG_CYC(SO1),
        .PULSE0_CYC(P0), .PULSE1_CYC(P1), .PULSE2_CYC(P2), .PULSE3_CYC(P3)) i_pbc_top (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .pushbutton_input_n(pushbutton_input_n),
        .force_off_n(force_off_n), .latch_out(latch_out), .int_n(int_n));
    pbc_sw_model i_pbc_sw_model (.hclk(hclk), .closed(closed), .bounce(bounce),
        .pushbutton_input_n(pushbutton_input_n));

    initial hclk = 1'b0;
    always #2 hclk = ~hclk;

    // Expected counts from the option bits
    function automatic logic [31:0] dbc(input logic b);
        return b ? DB1 : DB0;
    endfunction
    function automatic logic [31:0] soc(input logic b);
        return b ? SO1 : SO0;
    endfunction
    function automatic logic [31:0] pls(input logic [1:0] s);
        return (s == 2'h0) ? P0 : (s == 2'h1) ? P1 : (s == 2'h2) ? P2 : P3;
    endfunction
    // Measured count within twenty percent of nominal
    function automatic logic [31:0] tol(input int m, input logic [31:0] nom);
        return {31'h0, (m * 5 >= int'(nom) * 4) && (m * 5 <= int'(nom) * 6)};
    endfunction

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Every wait is bounded; running out ends the run as a failure
    task automatic tick(inout int c);
        c++;
        if (c > LIM) begin
            error_cnt++;
            $display("ERROR at %0t: wait %h limit %h", $time, c, LIM);
            end_of_test();
        end
    endtask
    // One single AHB-Lite transfer; entered just after a rising edge
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] d);
        int c;
        c = 0;
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        htrans <= 2'h2;
        do begin @(posedge hclk); tick(c); end while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do begin @(posedge hclk); tick(c); end while (hreadyout !== 1'b1);
        d = hrdata;
        chk({31'h0, hresp}, 32'h0000_0000);
    endtask
    // Edges with the contact low, restarting on any high sample, until int_n falls
    task automatic to_int(output int m);
        logic p;
        int   c;
        c = 0;
        m = 0;
        do begin
            p = int_n;
            @(posedge hclk);
            tick(c);
            m = (pushbutton_input_n === 1'b1) ? 0 : m + 1;
        end while (!(p === 1'b1 && int_n === 1'b0));
    endtask
    // Low width of int_n; optionally tries a clear early in the pulse
    task automatic width(output int m, input logic clr);
        int c;
        c = 0;
        m = 0;
        while (int_n === 1'b0) begin
            @(posedge hclk);
            tick(c);
            m++;
            if (clr && m == 1) force_off_n <= 1'b0;
            if (m == 2) force_off_n <= 1'b1;
        end
    endtask
    // Clear after lockout must act at once, with no clock edge
    task automatic clear_now;
        force_off_n <= 1'b0;
        #1 chk(latch_out, 32'h0000_0000);
        @(posedge hclk);
        force_off_n <= 1'b1;
    endtask

    initial begin
        seed = 6932;
        hresetn = 1'b0;
        {hsel, hwrite, closed, bounce} = 4'h0;
        force_off_n = 1'b1;
        haddr = 8'h00;
        htrans = 2'h0;
        hsize = 3'h2;
        hwdata = 32'h0000_0000;
        error_cnt = 0;
        n_checks = 0;
        repeat (10) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // Registers: reset values, masking, read-only and unmapped places
        chk({latch_out, int_n}, 32'h0000_0001);
        ahb(1'b0, 8'h00, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        k32 = $random(seed);
        ahb(1'b1, 8'h00, k32, rd);
        ahb(1'b1, 8'h04, 32'hFFFF_FFFF, rd);
        ahb(1'b1, 8'h08, 32'hFFFF_FFFF, rd);
        ahb(1'b0, 8'h08, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, 8'h04, 32'h0000_0000, rd);
        chk(rd, 32'h0000_0000);
        ahb(1'b0, 8'h00, 32'h0000_0000, rd);
        chk(rd, {27'h0, k32[4:0]});
        $display("test registers done");
        // Short presses, every pulse option, random debounce option
        for (k = 0; k < 4; k++) begin
            ctrl = {2'b00, 2'(k), 1'(k) ^ k32[6]};
            ahb(1'b1, 8'h00, {27'h0, ctrl}, rd);
            bounce <= 1'b1;
            closed <= 1'b1;
            w = 0;
            for (n = 0; n < 20; n++) begin
                if (n == 12) closed <= 1'b0;
                @(posedge hclk);
                if (int_n !== 1'b1 || latch_out !== 1'b0) w++;
            end
            chk(w, 32'h0000_0000);
            closed <= 1'b1;
            to_int(n);
            chk(tol(n, dbc(ctrl[0])), 32'h0000_0001);
            chk(latch_out, 32'h0000_0001);
            width(w, 1'b1);
            chk(w, pls(ctrl[2:1]));
            chk(latch_out, 32'h0000_0001);
            w = 0;
            repeat (2 * dbc(ctrl[0])) begin
                @(posedge hclk);
                if (int_n !== 1'b1) w++;
            end
            chk(w, 32'h0000_0000);
            closed <= 1'b0;
            repeat (10) @(posedge hclk);
            clear_now();
        end
        $display("test presses done");
        // Long presses, both variants, random shutoff and pulse options
        for (k = 0; k < 2; k++) begin
            ctrl = {1'(k), 1'(k) ^ k32[5], 2'($random(seed)), 1'b0};
            ahb(1'b1, 8'h00, {27'h0, ctrl}, rd);
            bounce <= 1'(k);
            closed <= 1'b1;
            to_int(n1);
            width(w, 1'b0);
            chk(w, pls(ctrl[2:1]));
            to_int(n);
            chk(tol(n1 + w + n, soc(ctrl[3])), 32'h0000_0001);
            width(w, 1'b0);
            chk(w, 4 * pls(ctrl[2:1]));
            chk(latch_out, {31'h0, ctrl[4]});
            ahb(1'b0, 8'h04, 32'h0000_0000, rd);
            chk(rd, {27'h0, 2'b00, ctrl[4], 2'h3});
            closed <= 1'b0;
            repeat (10) @(posedge hclk);
            clear_now();
        end
        $display("test long presses done");
        end_of_test();
    end
endmodule
`default_nettype wire
